// *** hw/ufi_pkg.sv ***
// Shared constants and carriers for the endpoint done-interrupt block.
// Assumes a single core clock; the serial engine sits on the same clock.
package ufi_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_EP = 6;
	localparam int FLAG_W = 2 * NUM_EP;
	localparam int LO_W = 8;
	localparam int HI_W = 4;
	localparam int EPC_W = 6;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ENABLE_LO = 8'hA2;
	localparam logic [7:0] OFS_ENABLE_HI = 8'hA3;
	localparam logic [7:0] OFS_IRQ_EN2 = 8'hA8;
	localparam logic [7:0] OFS_FLAGS_LO = 8'hC0;
	localparam logic [7:0] OFS_FLAGS_HI = 8'hC1;
	localparam logic [7:0] OFS_EPCTL_BASE = 8'hD0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_GLOBAL_ON = 7;
	localparam int EPC_RX_ON = 0;
	localparam int EPC_TX_ON = 1;
	localparam int EPC_RX_ALLOW = 2;
	localparam int EPC_TX_ALLOW = 3;
	localparam int EPC_RX_STALL = 4;
	localparam int EPC_TX_STALL = 5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 12'h000;
	localparam logic [FLAG_W-1:0] ENABLE_RESET = 12'h000;
	localparam logic [EPC_W-1:0] EPCTL_RESET = 6'h00;
	localparam logic GLOBAL_RESET = 1'b0;

	// Token kind of the finished transaction.
	typedef enum logic [1:0] {
		UFI_TOK_OUT = 2'b00,
		UFI_TOK_IN = 2'b01,
		UFI_TOK_SETUP = 2'b10,
		UFI_TOK_OTHER = 2'b11
	} ufi_tok_t;

	// One-cycle summary of a finished transaction from the serial engine.
	typedef struct packed {
		logic valid;
		logic [2:0] ep;
		ufi_tok_t tok;
		logic iso;
		logic rx_pkt_ok;
		logic pid_seq_err;
		logic tx_sent;
		logic tx_ack;
		logic timeout;
	} ufi_engine_evt_t;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ufi_bus_req_t;

endpackage

// *** hw/ufi_evt_qualify.sv ***
// Decides which done flags a finished transaction sets.
// Assumes the event is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module ufi_evt_qualify import ufi_pkg::*; #(
	parameter int N_EP = 6
) (
	// Transaction summary and endpoint controls.
	input wire ufi_engine_evt_t i_evt,
	input wire logic [N_EP*EPC_W-1:0] i_epctl,
	// Per-endpoint set requests.
	output logic [N_EP-1:0] o_rx_set,
	output logic [N_EP-1:0] o_tx_set
);

	// ------------------------------------------------------------
	// Per-endpoint qualification
	// ------------------------------------------------------------
	for (genvar k = 0; k < N_EP; k++) begin : g_ep
		wire [EPC_W-1:0] c = i_epctl[k*EPC_W +: EPC_W];
		// Isochronous traffic never reaches a flag.
		wire hit = i_evt.valid & ~i_evt.iso & (i_evt.ep == 3'(k));
		wire is_setup = i_evt.tok == UFI_TOK_SETUP;
		wire rx_tok = is_setup | (i_evt.tok == UFI_TOK_OUT);
		// A SETUP ignores the receive allow and stall bits.
		wire rx_gate = is_setup | (c[EPC_RX_ALLOW] & ~c[EPC_RX_STALL]);
		wire tx_gate = c[EPC_TX_ON] & c[EPC_TX_ALLOW] & ~c[EPC_TX_STALL];
		// Line errors still set the flag; a sequence error or a missing packet (rx_pkt_ok low) blocks it.
		assign o_rx_set[k] = hit & rx_tok & c[EPC_RX_ON] & rx_gate
			& i_evt.rx_pkt_ok & ~i_evt.pid_seq_err;
		assign o_tx_set[k] = hit & (i_evt.tok == UFI_TOK_IN) & tx_gate
			& i_evt.tx_sent & (i_evt.tx_ack | i_evt.timeout);
	end

endmodule // ufi_evt_qualify

// *** hw/ufi_bit_bank.sv ***
// A bank of bits written by software and set by hardware.
// Assumes write mask and set vector are on the core clock.
`timescale 1ns/1ps
module ufi_bit_bank #(
	parameter int W = 12,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Hardware sets and software writes.
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_wr_mask,
	input wire logic [W-1:0] i_wr_val,
	// Stored bits.
	output logic [W-1:0] o_q
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// A set in the same cycle as a clearing write wins, so no event is lost.
	assign q_next = (q_reg & ~i_wr_mask) | (i_wr_val & i_wr_mask) | i_set;

	// Storage.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q_reg <= RST;
		end else begin
			q_reg <= q_next;
		end
	end

	assign o_q = q_reg;

endmodule // ufi_bit_bank

// *** hw/ufi_func_irq.sv ***
// Endpoint receive-done and transmit-done flags, enables and request.
// Assumes the serial engine and the register master share i_clk.
//
// Operation
// - Receive-done needs a valid SETUP or OUT token to that endpoint.
// - Receive-done needs the endpoint reception enable set.
// - OUT needs receive allow set and receive stall clear; SETUP bypasses.
// - Receive-done sets on packet without timeout despite CRC or FIFO errors.
// - A data sequence PID error blocks receive-done.
// - Isochronous traffic never sets receive-done.
// - Transmit-done needs a valid IN token to that endpoint.
// - Transmit-done needs the endpoint transmission enable set.
// - Transmit-done needs transmit allow set and transmit stall clear.
// - Transmit-done needs a loaded packet sent for the IN token.
// - Transmit-done sets on host ACK or engine timeout.
// - Isochronous traffic never sets transmit-done.
// - A flag interrupts only while its enable is set; it still reads back.
// - Hardware only sets flags; firmware clears by writing; flags stay pending.
// - Firmware writing one sets a flag like hardware, raising the interrupt.
// - Low flag register: endpoints 3..0, receive above transmit.
// - High flag register: bits 7:4 reserved, zero; bits 3:0 endpoints 5,4.
// - High enable register: bits 7:4 reserved; bits 3:0 endpoints 5,4.
// - Low enable register mirrors the low flag register layout.
// - The global function enable gates every endpoint interrupt.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module ufi_func_irq import ufi_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port.
	input wire ufi_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// Serial engine transaction summary.
	input wire ufi_engine_evt_t i_engine_evt,
	// Function interrupt request.
	output logic o_irq
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// True when the address falls on one of the endpoint control slots.
	function automatic logic is_epctl(input logic [7:0] a);
		return (a >= OFS_EPCTL_BASE) && (a < OFS_EPCTL_BASE + 8'(NUM_EP));
	endfunction

	// Endpoint number behind an endpoint control address.
	function automatic logic [2:0] epctl_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFS_EPCTL_BASE;
		return d[2:0];
	endfunction

	// Register hits, shared by the write and read paths.
	wire hit_en_lo = i_bus.addr == OFS_ENABLE_LO;
	wire hit_en_hi = i_bus.addr == OFS_ENABLE_HI;
	wire hit_glob = i_bus.addr == OFS_IRQ_EN2;
	wire hit_fl_lo = i_bus.addr == OFS_FLAGS_LO;
	wire hit_fl_hi = i_bus.addr == OFS_FLAGS_HI;
	wire hit_epc = is_epctl(i_bus.addr);
	wire [2:0] epc_sel = epctl_idx(i_bus.addr);

	// Write strobes per register.
	wire wr_en_lo = i_bus.wr & hit_en_lo;
	wire wr_en_hi = i_bus.wr & hit_en_hi;
	wire wr_glob = i_bus.wr & hit_glob;
	wire wr_fl_lo = i_bus.wr & hit_fl_lo;
	wire wr_fl_hi = i_bus.wr & hit_fl_hi;

	// ------------------------------------------------------------
	// Endpoint control registers
	// ------------------------------------------------------------

	// One control word per endpoint; it qualifies the engine events.
	logic [EPC_W-1:0] epctl_reg [NUM_EP];
	logic [NUM_EP*EPC_W-1:0] epctl_vec;

	for (genvar k = 0; k < NUM_EP; k++) begin : g_epctl
		wire wr_k = i_bus.wr & hit_epc & (epc_sel == 3'(k));
		// Only the defined control bits are kept; upper data bits are dropped.
		always_ff @(posedge i_clk or posedge i_rst) begin
			if (i_rst) begin
				epctl_reg[k] <= EPCTL_RESET;
			end else if (wr_k) begin
				epctl_reg[k] <= i_bus.wdata[EPC_W-1:0];
			end
		end
		assign epctl_vec[k*EPC_W +: EPC_W] = epctl_reg[k];
	end

	// ------------------------------------------------------------
	// Global function enable
	// ------------------------------------------------------------
	logic global_reg;

	// Single gate bit in the second interrupt enable register.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			global_reg <= GLOBAL_RESET;
		end else if (wr_glob) begin
			global_reg <= i_bus.wdata[BIT_GLOBAL_ON];
		end
	end

	// ------------------------------------------------------------
	// Event qualification
	// ------------------------------------------------------------
	logic [NUM_EP-1:0] rx_set;
	logic [NUM_EP-1:0] tx_set;
	logic [FLAG_W-1:0] flag_set;

	ufi_evt_qualify #(
		.N_EP(NUM_EP)
	) u_qualify (
		.i_evt(i_engine_evt),
		.i_epctl(epctl_vec),
		.o_rx_set(rx_set),
		.o_tx_set(tx_set)
	);

	// Interleave so each endpoint owns a receive bit above a transmit bit.
	for (genvar k = 0; k < NUM_EP; k++) begin : g_pack
		assign flag_set[2*k+1] = rx_set[k];
		assign flag_set[2*k] = tx_set[k];
	end

	// ------------------------------------------------------------
	// Flags and enables
	// ------------------------------------------------------------

	// The high register only holds four bits; reserved writes fall away.
	wire [FLAG_W-1:0] wr_val = {i_bus.wdata[HI_W-1:0], i_bus.wdata};
	wire [FLAG_W-1:0] fl_mask = {{HI_W{wr_fl_hi}}, {LO_W{wr_fl_lo}}};
	wire [FLAG_W-1:0] en_mask = {{HI_W{wr_en_hi}}, {LO_W{wr_en_lo}}};
	logic [FLAG_W-1:0] flags_q;
	logic [FLAG_W-1:0] en_q;

	// Firmware writes store directly, so writing one sets a flag for test.
	ufi_bit_bank #(
		.W(FLAG_W),
		.RST(FLAGS_RESET)
	) u_flags (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(flag_set),
		.i_wr_mask(fl_mask),
		.i_wr_val(wr_val),
		.o_q(flags_q)
	);

	// Enables share the layout of the flags; hardware never sets them.
	ufi_bit_bank #(
		.W(FLAG_W),
		.RST(ENABLE_RESET)
	) u_enables (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set('0),
		.i_wr_mask(en_mask),
		.i_wr_val(wr_val),
		.o_q(en_q)
	);

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------

	// Disabled flags still show in the flag registers but raise nothing.
	wire [FLAG_W-1:0] live = flags_q & en_q;
	wire irq_next = global_reg & (|live);
	logic irq_reg;

	// Registered so the output is glitch free; costs one cycle of latency.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign o_irq = irq_reg;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	// Reserved high bits read as zero.
	wire [7:0] rd_glob = {7'h00, global_reg} << BIT_GLOBAL_ON;
	wire [7:0] rd_epc = is_epctl(i_bus.addr) ? {2'b00, epctl_reg[epc_sel]} : 8'h00;
	wire [7:0] rd_val =
		hit_en_lo ? en_q[LO_W-1:0] :
		hit_en_hi ? {4'h0, en_q[FLAG_W-1:LO_W]} :
		hit_glob ? rd_glob :
		hit_fl_lo ? flags_q[LO_W-1:0] :
		hit_fl_hi ? {4'h0, flags_q[FLAG_W-1:LO_W]} :
		rd_epc;
	logic [7:0] rdata_reg;

	// Read data stands only in the cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= i_bus.rd ? rd_val : 8'h00;
		end
	end

	assign o_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// Selected endpoint control word; guarded against out-of-range numbers.
	wire ev_ep_ok = i_engine_evt.ep < 3'(NUM_EP);
	wire [EPC_W-1:0] ev_ctl = ev_ep_ok ? epctl_reg[i_engine_evt.ep] : '0;

	// Firmware fills all low flags while every low enable and the gate are on.
	sequence s_fw_fill_lo;
		wr_fl_lo && (i_bus.wdata == 8'hFF);
	endsequence

	sequence s_all_on_lo;
		(en_q[LO_W-1:0] == 8'hFF) && global_reg;
	endsequence

	sequence s_quiet_bus;
		!i_bus.wr;
	endsequence

	a_fw_set_irq: assert property (
		s_fw_fill_lo ##0 s_all_on_lo ##1 s_quiet_bus |->
			(flags_q[LO_W-1:0] == 8'hFF) ##1 o_irq)
		else $error("firmware set did not raise the request");

	a_hw_set_lands: assert property (
		(flag_set != '0) |=> ((flags_q & $past(flag_set)) == $past(flag_set)))
		else $error("hardware set lost");

	a_flag_sticky: assert property (
		(flags_q[1] && !wr_fl_lo) |=> flags_q[1])
		else $error("flag cleared without a write");

	a_iso_no_set: assert property (
		i_engine_evt.iso |-> (flag_set == '0))
		else $error("isochronous event set a flag");

	a_pid_err_block: assert property (
		i_engine_evt.pid_seq_err |-> (rx_set == '0))
		else $error("receive-done set despite sequence error");

	a_out_stall_block: assert property (
		(i_engine_evt.tok == UFI_TOK_OUT && ev_ctl[EPC_RX_STALL]) |-> (rx_set == '0))
		else $error("OUT to stalled endpoint set receive-done");

	a_setup_bypass: assert property (
		(i_engine_evt.valid && !i_engine_evt.iso && ev_ep_ok
			&& i_engine_evt.tok == UFI_TOK_SETUP && ev_ctl[EPC_RX_ON]
			&& i_engine_evt.rx_pkt_ok && !i_engine_evt.pid_seq_err)
			|=> flags_q[2*$past(i_engine_evt.ep)+1])
		else $error("SETUP did not set receive-done");

	a_tx_handshake: assert property (
		(tx_set != '0) |-> (i_engine_evt.tx_sent && (i_engine_evt.tx_ack || i_engine_evt.timeout)))
		else $error("transmit-done without a sent and closed packet");

	a_tx_needs_in: assert property (
		(tx_set != '0) |-> (i_engine_evt.tok == UFI_TOK_IN && ev_ctl[EPC_TX_ON]
			&& ev_ctl[EPC_TX_ALLOW] && !ev_ctl[EPC_TX_STALL]))
		else $error("transmit-done without IN to an open endpoint");

	a_mask_quiet: assert property (
		(live == '0) |=> !o_irq)
		else $error("request raised with nothing enabled pending");

	a_global_gate: assert property (
		!global_reg |=> !o_irq)
		else $error("request raised with global enable off");

	a_rsvd_read: assert property (
		(i_bus.rd && (hit_fl_hi || hit_en_hi)) |=> (o_rdata[7:4] == 4'h0))
		else $error("reserved bits read non-zero");

	a_rdata_idle: assert property (
		!i_bus.rd |=> (o_rdata == 8'h00))
		else $error("read data outside the answer cycle");

	// A finished transaction on a real endpoint that is not isochronous.
	sequence s_ev_here;
		i_engine_evt.valid && !i_engine_evt.iso && ev_ep_ok;
	endsequence

	a_rx_needs_tok: assert property (
		(rx_set != '0) |-> (i_engine_evt.valid
			&& (i_engine_evt.tok == UFI_TOK_SETUP || i_engine_evt.tok == UFI_TOK_OUT)))
		else $error("receive-done without SETUP or OUT");

	a_rx_needs_on: assert property (
		(rx_set != '0) |-> ev_ctl[EPC_RX_ON])
		else $error("receive-done on an endpoint closed for reception");

	a_out_lands: assert property (
		s_ev_here ##0 (i_engine_evt.tok == UFI_TOK_OUT && ev_ctl[EPC_RX_ON]
			&& ev_ctl[EPC_RX_ALLOW] && !ev_ctl[EPC_RX_STALL]
			&& i_engine_evt.rx_pkt_ok && !i_engine_evt.pid_seq_err)
			|=> flags_q[2*$past(i_engine_evt.ep)+1])
		else $error("OUT to an open endpoint did not set receive-done");

	a_rx_no_packet: assert property (
		!i_engine_evt.rx_pkt_ok |-> (rx_set == '0))
		else $error("receive-done without a received packet");

	a_tx_lands: assert property (
		s_ev_here ##0 (i_engine_evt.tok == UFI_TOK_IN && ev_ctl[EPC_TX_ON]
			&& ev_ctl[EPC_TX_ALLOW] && !ev_ctl[EPC_TX_STALL]
			&& i_engine_evt.tx_sent
			&& (i_engine_evt.tx_ack || i_engine_evt.timeout))
			|=> flags_q[2*$past(i_engine_evt.ep)])
		else $error("closed IN transfer did not set transmit-done");

	a_fw_write_lo: assert property (
		wr_fl_lo |=> (flags_q[LO_W-1:0] == ($past(i_bus.wdata) | $past(flag_set[LO_W-1:0]))))
		else $error("low flag write not taken");

	a_fw_write_hi: assert property (
		wr_fl_hi |=> (flags_q[FLAG_W-1:LO_W]
			== ($past(i_bus.wdata[HI_W-1:0]) | $past(flag_set[FLAG_W-1:LO_W]))))
		else $error("high flag write not taken");

	a_en_write_lo: assert property (
		wr_en_lo |=> (en_q[LO_W-1:0] == $past(i_bus.wdata)))
		else $error("low enable write not taken");

	a_en_write_hi: assert property (
		wr_en_hi |=> (en_q[FLAG_W-1:LO_W] == $past(i_bus.wdata[HI_W-1:0])))
		else $error("high enable write not taken");

	a_en_hold: assert property (
		!(wr_en_lo || wr_en_hi) |=> $stable(en_q))
		else $error("enable changed without a write");

	a_irq_raise: assert property (
		(global_reg && (live != '0)) |=> o_irq)
		else $error("enabled pending flag raised no request");

	a_flag_read_lo: assert property (
		(i_bus.rd && hit_fl_lo) |=> (o_rdata == $past(flags_q[LO_W-1:0])))
		else $error("low flag read returned wrong bits");

	a_flag_read_hi: assert property (
		(i_bus.rd && hit_fl_hi)
			|=> (o_rdata[HI_W-1:0] == $past(flags_q[FLAG_W-1:LO_W])))
		else $error("high flag read returned wrong bits");

endmodule // ufi_func_irq

// *** bench/ufi_engine_model.sv ***
// Serial engine stand-in: turns a bench command into a one-cycle transaction summary.
// Assumes the bench raises i_go for one cycle per transaction, on the core clock.
`timescale 1ns/1ps
module ufi_engine_model import ufi_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Command from the bench.
	input wire logic i_go,
	input wire ufi_engine_evt_t i_cmd,
	// Summary towards the block.
	output ufi_engine_evt_t o_evt
);
	// ------------------------------------------------------------
	// Summary register
	// ------------------------------------------------------------
	// The qualifiers are inverted between transactions so nothing leans on stale values.
	// The summary carries no CRC or FIFO error bits; rx_pkt_ok only marks a packet without timeout.
	// The valid flag is the top bit of the summary, so one assignment covers it.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_evt <= '0;
		end else if (i_go) begin
			o_evt <= {1'b1, i_cmd[$bits(ufi_engine_evt_t)-2:0]};
		end else begin
			o_evt <= {1'b0, ~o_evt[$bits(ufi_engine_evt_t)-2:0]};
		end
	end
endmodule // ufi_engine_model

// *** bench/usb_function_endpoint_irq_tb_top.sv ***
// Self-checking bench for the endpoint done-interrupt block.
// Assumes one 200 MHz core clock shared by the register port and the serial engine.
`timescale 1ns/1ps
module usb_function_endpoint_irq_tb_top import ufi_pkg::*; ;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic go = 1'b0;
	ufi_bus_req_t bus = '0;
	ufi_engine_evt_t cmd = '0;
	ufi_engine_evt_t evt;
	logic [7:0] o_rdata;
	logic o_irq;
	logic [31:0] st = 32'h31;
	logic [11:0] shadow = '0;
	logic [11:0] en = '0;
	logic glob = 1'b0;
	logic [5:0] epc [0:7];
	int mismatches = 0;
	int checks_done = 0;
	localparam logic [7:0] RST_ADDR [0:7] = '{8'hA2, 8'hA3, 8'hA8, 8'hC0, 8'hC1, 8'hD0, 8'hD5, 8'h55};

	always #2.5 i_clk = ~i_clk;

	ufi_engine_model u_eng (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_cmd(cmd), .o_evt(evt));
	ufi_func_irq u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(o_rdata),
		.i_engine_evt(evt), .o_irq(o_irq));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction

	// Flags that one transaction should set, from the endpoint controls.
	function automatic logic [11:0] exp_set(ufi_engine_evt_t e, logic [5:0] c);
		logic rx;
		logic tx;
		logic [11:0] v;
		rx = (e.tok == UFI_TOK_SETUP || (e.tok == UFI_TOK_OUT && c[EPC_RX_ALLOW] && !c[EPC_RX_STALL]))
			&& c[EPC_RX_ON] && e.rx_pkt_ok && !e.pid_seq_err;
		tx = e.tok == UFI_TOK_IN && c[EPC_TX_ON] && c[EPC_TX_ALLOW] && !c[EPC_TX_STALL]
			&& e.tx_sent && (e.tx_ack || e.timeout);
		v = '0;
		if (e.ep < 3'd6 && !e.iso) begin
			v[2 * e.ep + 1] = rx;
			v[2 * e.ep] = tx;
		end
		return v;
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t request %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe is taken.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1;
		chk8(o_rdata, exp);
	endtask

	task automatic chkflags();
		rd(OFS_FLAGS_LO, shadow[7:0]);
		rd(OFS_FLAGS_HI, {4'h0, shadow[11:8]});
	endtask

	// One transaction; the request follows two cycles after the summary is taken.
	task automatic ev(input ufi_engine_evt_t e);
		@(posedge i_clk);
		go <= 1'b1;
		cmd <= e;
		@(posedge i_clk);
		go <= 1'b0;
		shadow = shadow | exp_set(e, epc[e.ep]);
		repeat (3) @(posedge i_clk);
		#1;
		chk1(o_irq, glob & |(shadow & en));
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	// A hang would otherwise run forever, so a watchdog ends the run.
	initial begin
		#400000;
		mismatches++;
		print_verdict();
	end

	initial begin
		logic [31:0] r;
		logic [31:0] q;
		ufi_engine_evt_t e;
		for (int i = 0; i < 8; i++) begin
			epc[i] = '0;
		end
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(RST_ADDR[i], 8'h00);
		end
		wr(OFS_EPCTL_BASE, 8'hFF);
		rd(OFS_EPCTL_BASE, 8'h3F);
		epc[0] = 6'h3F;
		wr(OFS_ENABLE_HI, 8'hFF);
		rd(OFS_ENABLE_HI, 8'h0F);
		wr(OFS_ENABLE_LO, 8'h5A);
		rd(OFS_ENABLE_LO, 8'h5A);
		en = 12'hF5A;
		wr(8'h55, 8'hFF);
		chkflags();
		// Setup passes a stalled, disallowed endpoint while OUT does not.
		wr(OFS_EPCTL_BASE + 8'h01, 8'h11);
		epc[1] = 6'h11;
		e = '{valid: 1'b1, ep: 3'd1, tok: UFI_TOK_OUT, rx_pkt_ok: 1'b1, default: 1'b0};
		ev(e);
		e.tok = UFI_TOK_SETUP;
		ev(e);
		chkflags();
		// Firmware alone raises the request once every low enable and the gate are on.
		wr(OFS_FLAGS_LO, 8'h00);
		shadow[7:0] = 8'h00;
		en = 12'hFFF;
		glob = 1'b1;
		wr(OFS_ENABLE_LO, 8'hFF);
		wr(OFS_IRQ_EN2, 8'h80);
		#1;
		chk1(o_irq, 1'b0);
		wr(OFS_FLAGS_LO, 8'hFF);
		shadow[7:0] = 8'hFF;
		repeat (2) @(posedge i_clk);
		#1;
		chk1(o_irq, 1'b1);
		chkflags();
		for (int n = 0; n < 250; n++) begin
			r = xs();
			q = xs();
			if (r[2:0] == 3'd0) begin
				wr(OFS_FLAGS_LO, q[31:24]);
				wr(OFS_FLAGS_HI, {4'h0, q[23:20]});
				shadow = {q[23:20], q[31:24]};
			end
			glob = r[3] | r[4];
			en = {q[19:16], q[15:8]};
			wr(OFS_ENABLE_LO, q[15:8]);
			wr(OFS_ENABLE_HI, {r[31:28], q[19:16]});
			wr(OFS_IRQ_EN2, {glob, 7'h00});
			e.ep = r[7:5];
			if (e.ep < 3'd6) begin
				epc[e.ep] = r[14] ? 6'h0F : r[13:8];
				wr(OFS_EPCTL_BASE + {5'h00, e.ep}, {2'b00, epc[e.ep]});
			end
			e.valid = 1'b1;
			e.tok = ufi_tok_t'(r[16:15]);
			e.iso = r[17] & r[18];
			e.rx_pkt_ok = r[19] | r[20];
			e.pid_seq_err = r[21] & r[22];
			e.tx_sent = r[23] | r[24];
			e.tx_ack = r[25];
			e.timeout = r[26];
			ev(e);
			chkflags();
		end
		print_verdict();
	end
endmodule // usb_function_endpoint_irq_tb_top
